// ---- hdl/mdspi_pkg.sv ----
package mdspi_pkg;

  // ==========================================================
  // Command word layout
  localparam int unsigned WORD_W    = 16;
  localparam int unsigned CMD_WR_BIT = 15;
  localparam int unsigned SEL_HI    = 14;
  localparam int unsigned SEL_LO    = 13;
  localparam int unsigned CNT_W     = 4;

  // ==========================================================
  // Register selects
  typedef enum logic [1:0] {
    MDSPI_SEL_IDENT  = 2'b00,
    MDSPI_SEL_STATUS = 2'b01,
    MDSPI_SEL_MASK   = 2'b10,
    MDSPI_SEL_CONFIG = 2'b11
  } mdspi_sel_t;

  // ==========================================================
  // Status and mask bit positions
  localparam int unsigned FAULT_W      = 12;
  localparam int unsigned DET_W        = 11;
  localparam int unsigned ST_FRAMING   = 11;
  localparam int unsigned ST_THERM_WRN = 1;
  localparam int unsigned MASK_HSPOFF  = 12;

  // ==========================================================
  // Configuration bit positions
  localparam int unsigned CF_LOAD_CHK  = 12;
  localparam int unsigned CF_THERM_MGT = 11;
  localparam int unsigned CF_ACT_LIM   = 10;
  localparam int unsigned CF_CURRENT_LIMIT_SELECT_HI   = 9;
  localparam int unsigned CF_CURRENT_LIMIT_SELECT_LO   = 8;
  localparam int unsigned CF_SLEW_HI   = 7;
  localparam int unsigned CF_SLEW_LO   = 5;
  localparam int unsigned CF_OUT_EN    = 4;
  localparam int unsigned CF_HBRIDGE   = 3;
  localparam int unsigned CF_VIRT_SEL  = 2;
  localparam int unsigned CF_VIRT_B    = 1;
  localparam int unsigned CF_VIRT_A    = 0;

  // ==========================================================
  // Reset values
  localparam logic [12:0] MASK_RST   = 13'h06F1;
  localparam logic [12:0] CONFIG_RST = 13'h0D98;
  localparam logic [11:0] STATUS_RST = 12'h000;

  // ==========================================================
  // Commands presented to the driver stage
  typedef struct packed {
    logic       outputs_enable;
    logic       bridge_mode;
    logic       drive_a;
    logic       drive_b;
    logic [1:0] current_limit_select;
    logic [2:0] slew_select;
    logic       active_current_limit;
    logic       high_supply_protect;
    logic       load_check_enable;
    logic       load_check_start;
    logic       fast_blanking;
  } mdspi_drive_t;

  // Serial pin group
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic mosi;
  } mdspi_serial_t;

endpackage

// ---- hdl/mdspi_regs.sv ----
// Functional notes
// - Command bit 15 high means write.
// - Bits 14:13 pick ident, status, mask, config.
// - Fault bits latch when detected, hold.
// - Clear only faults no longer present.
// - Shutoff pin falling edge clears inactive faults.
// - Wake pin rising edge clears inactive faults.
// - Status write of one clears inactive faults.
// - Bad clock count ignores frame, flags framing.
// - Write to identification is a framing error.
// - Identification reads zeros plus revision, id bit.
// - Status bits 11:0 hold the listed faults.
// - Status fault bits read zero without faults.
// - Masked active faults drive fault flag low.
// - Mask bit 12 makes overvoltage warning only.
// - Load check enable, test on rising write.
// - Thermal management gates fast blanking.
// - Active current limit enable bit.
// - Output enable bit gates drive outputs.
// - Config bit 3 selects full or half bridge.
// - Config bit 2 selects virtual or pin drive.
// - Virtual bits act as drive pins.
// - Half bridge drops limit, load check, protection.
// - MSB first, sample falling, shift rising.
// - Reply is register chosen by prior command.
// - First reply after wake is status.
// - Read commands ignore low content bits.
module mdspi_regs #(
  parameter logic [3:0] REVISION  = 4'h1, // Arbitrary value
  parameter logic       DEVICE_ID = 1'b0  // Arbitrary value
) (
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  // Serial link pins
  input  wire mdspi_pkg::mdspi_serial_t serial_in,
  output logic                         spi_miso_o,
  output logic                         spi_miso_oe_n,
  // Control pins
  input  wire logic                    wake_pin,
  input  wire logic                    shutoff_pin,
  input  wire logic                    drive_pin_a,
  input  wire logic                    drive_pin_b,
  // Fault detectors, bits 10:0 of status order
  input  wire logic [10:0]             fault_detect,
  // Driver stage
  output logic                         fault_flag_n,
  output mdspi_pkg::mdspi_drive_t      drive
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [2:0]           sclk_s;
    logic [2:0]           cs_s;
    logic [1:0]           mosi_s;
    logic [2:0]           wake_s;
    logic [2:0]           shut_s;
    logic [1:0]           pin_a_s;
    logic [1:0]           pin_b_s;
    logic [1:0][10:0]     det_s;
    logic [15:0]          rx;
    logic [15:0]          tx;
    logic [3:0]           cnt;
    logic                 seen;
    mdspi_pkg::mdspi_sel_t sel;
    logic [11:0]          status;
    logic [12:0]          mask;
    logic [12:0]          cfg;
    logic                 flag_n;
    mdspi_pkg::mdspi_drive_t drv;
  } mdspi_state_t;

  mdspi_state_t st_q;
  mdspi_state_t st_d;

  logic [11:0] cond;
  logic [11:0] clr;
  logic        frm_set;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        cs_fall;
  logic        cs_rise;
  logic        hbridge;
  logic [15:0] cmd;
  logic [15:0] reply;

  always_comb
  begin
    st_d = st_q;
    // Two-stage sync; only stage two and later are looked at
    st_d.sclk_s  = {st_q.sclk_s[1:0], serial_in.sclk};
    st_d.cs_s    = {st_q.cs_s[1:0], serial_in.cs_n};
    st_d.mosi_s  = {st_q.mosi_s[0], serial_in.mosi};
    st_d.wake_s  = {st_q.wake_s[1:0], wake_pin};
    st_d.shut_s  = {st_q.shut_s[1:0], shutoff_pin};
    st_d.pin_a_s = {st_q.pin_a_s[0], drive_pin_a};
    st_d.pin_b_s = {st_q.pin_b_s[0], drive_pin_b};
    st_d.det_s   = {st_q.det_s[0], fault_detect};

    sclk_rise = st_q.sclk_s[1] & ~st_q.sclk_s[2];
    sclk_fall = ~st_q.sclk_s[1] & st_q.sclk_s[2];
    cs_fall   = ~st_q.cs_s[1] & st_q.cs_s[2];
    cs_rise   = st_q.cs_s[1] & ~st_q.cs_s[2];
    cond      = {1'b0, st_q.det_s[1]};
    cmd       = st_q.rx;
    clr       = 12'h000;
    frm_set   = 1'b0;

    // Reply word carries its select in bits 14:13
    unique case (st_q.sel)
      mdspi_pkg::MDSPI_SEL_IDENT:
        reply = {11'h000, DEVICE_ID, REVISION};
      mdspi_pkg::MDSPI_SEL_STATUS:
        reply = {1'b0, st_q.sel, 1'b0, st_q.status};
      mdspi_pkg::MDSPI_SEL_MASK:
        reply = {1'b0, st_q.sel, st_q.mask};
      mdspi_pkg::MDSPI_SEL_CONFIG:
        reply = {1'b0, st_q.sel, st_q.cfg};
    endcase

    // ==========================================================
    // Serial shifting
    if (cs_fall)
    begin
      st_d.tx   = reply;
      st_d.cnt  = 4'h0;
      st_d.seen = 1'b0;
    end
    else if (!st_q.cs_s[1])
    begin
      if (sclk_fall)
      begin
        // Keeps last sixteen bits, so longer daisy chains work
        st_d.rx   = {st_q.rx[14:0], st_q.mosi_s[1]};
        st_d.cnt  = st_q.cnt + 4'h1;
        st_d.seen = 1'b1;
      end
      if (sclk_rise && st_q.seen)
        st_d.tx = {st_q.tx[14:0], st_q.rx[0]};
    end

    // ==========================================================
    // Frame end decode
    if (cs_rise)
    begin
      if (!st_q.seen || st_q.cnt != 4'h0)
        frm_set = 1'b1;
      else if (cmd[mdspi_pkg::CMD_WR_BIT])
      begin
        unique case (mdspi_sel_e(cmd))
          mdspi_pkg::MDSPI_SEL_IDENT:
            frm_set = 1'b1;
          mdspi_pkg::MDSPI_SEL_STATUS:
          begin
            clr = cmd[11:0];
            st_d.sel = mdspi_pkg::MDSPI_SEL_STATUS;
          end
          mdspi_pkg::MDSPI_SEL_MASK:
          begin
            st_d.mask = cmd[12:0];
            st_d.sel  = mdspi_pkg::MDSPI_SEL_MASK;
          end
          mdspi_pkg::MDSPI_SEL_CONFIG:
          begin
            st_d.cfg = cmd[12:0];
            st_d.sel = mdspi_pkg::MDSPI_SEL_CONFIG;
          end
        endcase
      end
      else
        st_d.sel = mdspi_sel_e(cmd);
    end

    // ==========================================================
    // Fault latching and clearing
    if (st_q.shut_s[2] && !st_q.shut_s[1])
      clr = 12'hFFF;
    if (st_q.wake_s[1] && !st_q.wake_s[2])
    begin
      clr      = 12'hFFF;
      st_d.sel = mdspi_pkg::MDSPI_SEL_STATUS;
    end
    // New detections win over a clear in the same cycle
    st_d.status = (st_q.status & ~(clr & ~cond)) | cond;
    if (frm_set)
      st_d.status[mdspi_pkg::ST_FRAMING] = 1'b1;

    // ==========================================================
    // Outputs
    hbridge = st_q.cfg[mdspi_pkg::CF_HBRIDGE];
    st_d.flag_n = ~|(st_q.status & st_q.mask[11:0]);
    st_d.drv.bridge_mode = hbridge;
    st_d.drv.outputs_enable = st_q.cfg[mdspi_pkg::CF_OUT_EN]
                              & st_q.wake_s[1] & ~st_q.shut_s[1];
    if (st_q.cfg[mdspi_pkg::CF_VIRT_SEL])
    begin
      st_d.drv.drive_a = st_q.cfg[mdspi_pkg::CF_VIRT_A];
      st_d.drv.drive_b = st_q.cfg[mdspi_pkg::CF_VIRT_B];
    end
    else
    begin
      st_d.drv.drive_a = st_q.pin_a_s[1];
      st_d.drv.drive_b = st_q.pin_b_s[1];
    end
    st_d.drv.current_limit_select =
      st_q.cfg[mdspi_pkg::CF_CURRENT_LIMIT_SELECT_HI:mdspi_pkg::CF_CURRENT_LIMIT_SELECT_LO];
    st_d.drv.slew_select =
      st_q.cfg[mdspi_pkg::CF_SLEW_HI:mdspi_pkg::CF_SLEW_LO];
    st_d.drv.active_current_limit =
      st_q.cfg[mdspi_pkg::CF_ACT_LIM] & hbridge;
    st_d.drv.high_supply_protect =
      ~st_q.mask[mdspi_pkg::MASK_HSPOFF] & hbridge;
    st_d.drv.load_check_enable =
      st_q.cfg[mdspi_pkg::CF_LOAD_CHK] & hbridge;
    st_d.drv.load_check_start = hbridge
      & st_d.cfg[mdspi_pkg::CF_LOAD_CHK]
      & ~st_q.cfg[mdspi_pkg::CF_LOAD_CHK];
    // Without thermal management blanking stays at slowest
    st_d.drv.fast_blanking = st_q.cfg[mdspi_pkg::CF_THERM_MGT]
      & cond[mdspi_pkg::ST_THERM_WRN];
  end

  function automatic mdspi_pkg::mdspi_sel_t mdspi_sel_e(input logic [15:0] w);
    mdspi_sel_e = mdspi_pkg::mdspi_sel_t'(w[mdspi_pkg::SEL_HI:mdspi_pkg::SEL_LO]);
  endfunction

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q        <= '0;
      st_q.sclk_s <= 3'h0;
      st_q.cs_s   <= 3'h7;
      st_q.shut_s <= 3'h0;
      st_q.sel    <= mdspi_pkg::MDSPI_SEL_STATUS;
      st_q.status <= mdspi_pkg::STATUS_RST;
      st_q.mask   <= mdspi_pkg::MASK_RST;
      st_q.cfg    <= mdspi_pkg::CONFIG_RST;
      st_q.flag_n <= 1'b1;
    end
    else
      st_q <= st_d;
  end

  assign spi_miso_o    = st_q.tx[15];
  assign spi_miso_oe_n = st_q.cs_s[1];
  assign fault_flag_n  = st_q.flag_n;
  assign drive         = st_q.drv;

endmodule // mdspi_regs

// ---- testbench/mdspi_host.sv ----
module mdspi_host
(
  // Serial pins toward the device
  output mdspi_pkg::mdspi_serial_t ser,
  // Sampling clock and reply line
  input  wire logic                clk,
  input  wire logic                miso
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Frame driver
  initial ser = '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0};

  // Link clock idles low, 160 ns period, stands still outside frames
  task automatic frame(input logic [15:0] w, input int n, output logic [15:0] rx);
    rx = '0;
    @(negedge clk) ser.cs_n = 1'b0;
    repeat (8) @(negedge clk);
    for (int i = 0; i < n; i++)
    begin
      ser.mosi = w[15 - i];
      ser.sclk = 1'b1;
      repeat (4) @(negedge clk);
      rx = {rx[14:0], miso};
      ser.sclk = 1'b0;
      repeat (4) @(negedge clk);
    end
    ser.cs_n = 1'b1;
    ser.mosi = ~ser.mosi; // Last bit inverted, no stale bit
    repeat (20) @(negedge clk);
  endtask
endmodule // mdspi_host

// ---- testbench/mdspi_regs_checker.sv ----
module mdspi_regs_checker
(
  // Clock and reset
  input wire logic                    ref_clk,
  input wire logic                    rst_n,
  // Serial pins
  input wire mdspi_pkg::mdspi_serial_t serial_in,
  input wire logic                    spi_miso_o,
  input wire logic                    spi_miso_oe_n,
  // Control pins
  input wire logic                    wake_pin,
  input wire logic                    shutoff_pin,
  input wire logic                    drive_pin_a,
  input wire logic                    drive_pin_b,
  input wire logic [10:0]             fault_detect,
  // Driver stage
  input wire logic                    fault_flag_n,
  input wire mdspi_pkg::mdspi_drive_t drive
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // Sequences
  // Six quiet cycles outlast the sync and decode lag
  sequence s_idle; serial_in.cs_n [*6]; endsequence
  sequence s_quiet; (serial_in.cs_n && $stable(wake_pin) && $stable(shutoff_pin)) [*6];
  endsequence
  sequence s_lead; (!serial_in.sclk && !serial_in.cs_n) [*7]; endsequence

  // ==========================================================
  // Properties
  property p_oe_idle; s_idle |-> spi_miso_oe_n; endproperty
  property p_flag_held; s_quiet ##0 !fault_flag_n |=> !fault_flag_n; endproperty
  property p_wake_off; (!wake_pin) [*6] |-> !drive.outputs_enable; endproperty
  property p_shut_off; shutoff_pin [*6] |-> !drive.outputs_enable; endproperty
  property p_half; !drive.bridge_mode |-> !drive.active_current_limit &&
    !drive.load_check_enable && !drive.high_supply_protect; endproperty
  property p_chk_pulse; drive.load_check_start |=> !drive.load_check_start; endproperty
  property p_chk_mode; drive.load_check_start |-> drive.bridge_mode; endproperty
  property p_miso_lead; s_lead |-> $stable(spi_miso_o); endproperty
  property p_fields; s_idle |-> $stable(drive.current_limit_select) &&
    $stable(drive.slew_select) && $stable(drive.bridge_mode); endproperty

  a_oe_idle: assert property (p_oe_idle) else $error("miso driven while deselected");
  a_flag_held: assert property (p_flag_held) else $error("fault flag dropped");
  a_wake_off: assert property (p_wake_off) else $error("outputs on, wake low");
  a_shut_off: assert property (p_shut_off) else $error("outputs on, shutoff");
  a_half: assert property (p_half) else $error("half bridge feature on");
  a_chk_pulse: assert property (p_chk_pulse) else $error("check start long");
  a_chk_mode: assert property (p_chk_mode) else $error("check in half bridge");
  a_miso_lead: assert property (p_miso_lead) else $error("miso moved, no edge");
  a_fields: assert property (p_fields) else $error("fields moved, no frame");
endmodule // mdspi_regs_checker

bind mdspi_regs mdspi_regs_checker u_mdspi_regs_checker (.ref_clk(ref_clk), .rst_n(rst_n),
  .serial_in(serial_in), .spi_miso_o(spi_miso_o), .spi_miso_oe_n(spi_miso_oe_n),
  .wake_pin(wake_pin), .shutoff_pin(shutoff_pin), .drive_pin_a(drive_pin_a),
  .drive_pin_b(drive_pin_b), .fault_detect(fault_detect), .fault_flag_n(fault_flag_n),
  .drive(drive));

// ---- testbench/testbench.sv ----
`define CHK(nm, exp, got) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      n_mismatch++; \
      $display("ERROR %s expected %h seen %h", nm, exp, got); \
    end \
  end

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Pins and model state
  logic                     ref_clk = 1'b0;
  logic                     rst_n = 1'b0;
  logic                     wake_pin = 1'b1;
  logic                     shutoff_pin = 1'b0;
  logic                     drive_pin_a = 1'b0;
  logic                     drive_pin_b = 1'b0;
  logic [10:0]              fault_detect = '0;
  mdspi_pkg::mdspi_serial_t serial_in;
  mdspi_pkg::mdspi_drive_t  drive;
  logic                     spi_miso_o;
  logic                     spi_miso_oe_n;
  logic                     fault_flag_n;
  wire logic                miso_line = spi_miso_oe_n ? 1'bz : spi_miso_o;
  logic [15:0]              rx;
  logic [11:0]              st = '0;
  logic [12:0]              mk = 13'h06F1;
  logic [12:0]              cf = 13'h0D98;
  int                       sel = 1;
  int                       n_mismatch = 0;
  int                       total_checks = 0;

  always #10 ref_clk = ~ref_clk;

  // Revision and id values are arbitrary
  mdspi_regs #(.REVISION(4'h9), .DEVICE_ID(1'b1)) u_mdspi_regs (.ref_clk(ref_clk),
    .rst_n(rst_n), .serial_in(serial_in), .spi_miso_o(spi_miso_o),
    .spi_miso_oe_n(spi_miso_oe_n), .wake_pin(wake_pin), .shutoff_pin(shutoff_pin),
    .drive_pin_a(drive_pin_a), .drive_pin_b(drive_pin_b), .fault_detect(fault_detect),
    .fault_flag_n(fault_flag_n), .drive(drive));
  mdspi_host u_mdspi_host (.ser(serial_in), .clk(ref_clk), .miso(miso_line));

  // ==========================================================
  // Model and tasks
  function automatic logic [15:0] reply(int s);
    if (s == 0)
      return 16'h0019;
    return 16'((s << 13) | (s == 1 ? 13'(st) : s == 2 ? mk : cf));
  endfunction

  task automatic xfer(input logic [15:0] w, input int n);
    logic [15:0] e;
    e = reply(sel);
    u_mdspi_host.frame(w, n, rx);
    if (n != 16 || (w[15] && w[14:13] == 2'b00))
      st[11] = 1'b1;
    else
    begin
      sel = int'(w[14:13]);
      if (w[15] && sel == 1) st = st & ~(w[11:0] & ~{1'b0, fault_detect});
      if (w[15] && sel == 2) mk = w[12:0];
      if (w[15] && sel == 3) cf = w[12:0];
      `CHK("reply", e, rx)
    end
    st = st | {1'b0, fault_detect};
    `CHK("fault flag", ~|(st & mk[11:0]), fault_flag_n)
    `CHK("drive", {cf[4] & wake_pin & ~shutoff_pin, cf[3], cf[2] ? cf[0] : drive_pin_a,
      cf[2] ? cf[1] : drive_pin_b, cf[9:5], cf[10] & cf[3], cf[3] & ~mk[12],
      cf[12] & cf[3], 1'b0, cf[11] & fault_detect[1]}, drive)
  endtask

  task automatic set_det(input logic [10:0] v);
    fault_detect = v;
    repeat (6) @(negedge ref_clk);
    st = st | {1'b0, v};
  endtask

  // Pulses outlast 1 us so the clear is guaranteed
  task automatic pulse(input bit wk);
    if (wk) wake_pin = 1'b0; else shutoff_pin = 1'b1;
    repeat (60) @(negedge ref_clk);
    wake_pin = 1'b1;
    shutoff_pin = 1'b0;
    repeat (10) @(negedge ref_clk);
    st = st & {1'b0, fault_detect};
    if (wk) sel = 1;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ==========================================================
  // Tests
  initial
  begin
    void'($urandom(43));
    repeat (12) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (6) @(negedge ref_clk);
    xfer(16'h2000, 16);
    for (int s = 0; s < 4; s++) xfer({1'b0, 2'(s), 13'($urandom)}, 16);
    for (int k = 0; k < 6; k++)
    begin
      drive_pin_a = 1'($urandom);
      drive_pin_b = 1'($urandom);
      xfer({3'b110, 13'($urandom)}, 16);
      xfer({3'b111, 13'($urandom) & 13'h0FFF}, 16);
    end
    xfer({3'b111, 13'h0818}, 16);
    xfer({3'b111, 13'h1818}, 16);
    xfer({3'b110, 13'h0FFF}, 16);
    for (int i = 0; i < 11; i++)
    begin
      set_det(11'(1 << i));
      xfer({3'b101, 13'h0FFF}, 16);
      set_det('0);
      xfer({3'b101, 13'h0FFF}, 16);
    end
    set_det(11'h7FF);
    set_det('0);
    pulse(1'b1);
    xfer(16'h4000, 16);
    set_det(11'h155);
    set_det('0);
    pulse(1'b0);
    xfer(16'h2000, 16);
    xfer(16'hA000, 8);
    xfer(16'h2000, 0);
    xfer(16'h8123, 16);
    xfer({3'b101, 13'h0800}, 16);
    xfer(16'h2000, 16);
    tally_and_finish();
  end

  // Generous bound, the sequence needs about 7800 cycles
  initial
  begin
    repeat (40000) @(posedge ref_clk);
    n_mismatch++;
    tally_and_finish();
  end
endmodule // testbench
